// File: tb_tpg_port.sv
`timescale 1ns/1ps
module tb_tpg_port
    import tpg_pkg::*;
;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, stop_mode, watch_mode, trg_one, trg_two;
    logic [3:0]  awaddr, wstrb;
    logic [4:0]  araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r, br, pin_in, ext_en, ext_val;
    tpg_pad_s    pad;
    int          num_errors, n_compared, cyc;

    tpg_port u_tpg_port (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .stop_mode(stop_mode), .watch_mode(watch_mode),
        .pin_in(pin_in), .pad(pad), .position_trigger_one(trg_one),
        .position_trigger_two(trg_two));

    tpg_pin_model u_tpg_pin_model (.clk(clk), .pad(pad), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            conclude();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic conclude();
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; wstrb <= 4'hf;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        br = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = 4'h0; wdata = 32'h0; wstrb = 4'h0; araddr = 5'h0;
        stop_mode = 1'b0; watch_mode = 1'b0; ext_en = 2'h3; ext_val = 2'h1;
        num_errors = 0; n_compared = 0; cyc = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(5'h04, d, r); chk(d, 32'h0);
        rd(5'h08, d, r); chk(d, 32'h0);
        chk(pad.oe, 2'h0);
        wr(4'h0, 32'hffffffff);
        chk(br, TPG_RESP_OKAY);
        rd(5'h10, d, r); chk(d, 32'h6);
        rd(5'h00, d, r); chk(d, 32'h2);
        chk(pad.oe, 2'h0);
        chk({trg_two, trg_one}, 2'h1);
        wr(4'h4, 32'hff);
        repeat (2) @(posedge clk);
        chk({pad.oe, pad.out}, 4'hf);
        chk({trg_two, trg_one}, 2'h3);
        rd(5'h04, d, r); chk(d, 32'h6);
        rd(5'h00, d, r); chk(d, 32'h6);
        wr(4'h0, 32'h2);
        wr(4'h8, 32'h6);
        repeat (2) @(posedge clk);
        chk(pad.out, 2'h1);
        chk(pad.pu, 2'h1);
        ext_en <= 2'h0;
        wr(4'hc, 32'h1);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk);
        chk({pad.oe, pad.pu}, 4'h0);
        chk({trg_two, trg_one}, 2'h0);
        rd(5'h0c, d, r); chk(d, 32'h3);
        stop_mode <= 1'b0;
        watch_mode <= 1'b1;
        wr(4'hc, 32'h0);
        repeat (3) @(posedge clk);
        chk({pad.oe, pad.out}, 4'hd);
        rd(5'h14, d, r); chk(d, 32'h0);
        chk(r, TPG_RESP_SLVERR);
        conclude();
    end
endmodule

// File: tpg_pad.sv
`timescale 1ns/1ps
module tpg_pad
    import tpg_pkg::*;
(
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic pu_sel,
    input  wire logic pin_in,
    input  wire logic float_en,
    output logic      oe,
    output logic      out,
    output logic      pu,
    output logic      in_gated
);
    // ****************************************
    // One pin cell
    // ****************************************
    assign oe       = dir & ~float_en;
    assign out      = latch;
    assign pu       = pu_sel & ~float_en & ~(oe & ~latch);
    assign in_gated = pin_in & ~float_en;
endmodule

// File: tpg_pin_model.sv
`timescale 1ns/1ps
module tpg_pin_model
    import tpg_pkg::*;
(
    input  wire logic       clk,
    input  wire tpg_pad_s   pad,
    input  wire logic [1:0] ext_en,
    input  wire logic [1:0] ext_val,
    output logic [1:0]      pin_in
);
    // ****************************************
    // Pin level resolution
    // ****************************************
    logic [1:0] alt_r = 2'h1;

    // Open pins wander so a stale level never passes
    always_ff @(posedge clk) begin
        alt_r <= ~alt_r;
    end

    // Outside drive only where the port is not driving
    assign pin_in = (pad.oe & pad.out)
                  | (~pad.oe & ext_en & ext_val)
                  | (~pad.oe & ~ext_en & (pad.pu | alt_r));
endmodule

// File: tpg_pkg.sv
package tpg_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] TPG_OFS_LATCH   = 4'h0;
    localparam logic [3:0] TPG_OFS_DIR     = 4'h4;
    localparam logic [3:0] TPG_OFS_PULLUP  = 4'h8;
    localparam logic [3:0] TPG_OFS_STANDBY = 4'hc;
    localparam logic [3:0] TPG_OFS_RMW     = 4'h0;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int         TPG_PIN_LO      = 1;
    localparam int         TPG_PIN_HI      = 2;
    localparam logic [7:0] TPG_PIN_MASK    = 8'h06;
    localparam int         TPG_SPL_BIT     = 0;
    localparam int         TPG_STOP_BIT    = 1;
    localparam int         TPG_WATCH_BIT   = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] TPG_RST_LATCH   = 8'h00;
    localparam logic [7:0] TPG_RST_DIR     = 8'h00;
    localparam logic [7:0] TPG_RST_PULLUP  = 8'h00;
    localparam logic [2:0] TPG_RST_STANDBY = 3'h0;

    localparam logic [1:0] TPG_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TPG_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] oe;
        logic [1:0] out;
        logic [1:0] pu;
    } tpg_pad_s;

endpackage

// File: tpg_port.sv
`timescale 1ns/1ps
// How it works
// - Direction one drives pin from latch
// - Output pin shows latch bit
// - Latch write appears on output pins
// - Output pin read returns latch
// - Direction zero makes pin input
// - Input pin latch writes stored only
// - Input read gives pin, RMW latch
// - Peripheral inputs still read pin level
// - Reset clears all direction bits
// - Standby float: Hi-Z, input low
// - No float: configuration and level kept
// - Pull-up bit connects pull-up
// - Driving low disconnects pull-up
// - Pins sit at bits two, one
// - Pin levels go to position triggers
module tpg_port
    import tpg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        stop_mode,
    input  wire logic        watch_mode,
    input  wire logic [1:0]  pin_in,
    output tpg_pad_s         pad,
    output logic             position_trigger_one,
    output logic             position_trigger_two
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  port_output_latch_r;
    logic [7:0]  port_direction_r;
    logic [7:0]  port_pullup_enable_r;
    logic        standby_pin_state_sel_r;
    logic [3:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        aw_have_r;
    logic        w_have_r;

    // ****************************************
    // Write path
    // ****************************************
    wire       aw_take  = s_axi_awvalid & s_axi_awready;
    wire       w_take   = s_axi_wvalid & s_axi_wready;
    wire       wr_go    = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire       wr_lo    = w_strb_r[0];
    wire [7:0] wbyte    = w_data_r[7:0] & TPG_PIN_MASK;
    wire       wr_latch = wr_go & wr_lo & (aw_addr_r == TPG_OFS_LATCH);
    wire       wr_dir   = wr_go & wr_lo & (aw_addr_r == TPG_OFS_DIR);
    wire       wr_pu    = wr_go & wr_lo & (aw_addr_r == TPG_OFS_PULLUP);
    wire       wr_stby  = wr_go & wr_lo & (aw_addr_r == TPG_OFS_STANDBY);
    wire       wr_hit   = (aw_addr_r == TPG_OFS_LATCH) | (aw_addr_r == TPG_OFS_DIR)
                        | (aw_addr_r == TPG_OFS_PULLUP) | (aw_addr_r == TPG_OFS_STANDBY);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= 4'h0;
            w_data_r      <= 32'h0;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= TPG_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_have_r & ~aw_take & ~s_axi_bvalid;
            s_axi_wready  <= ~w_have_r & ~w_take & ~s_axi_bvalid;
            if (aw_take) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? TPG_RESP_OKAY : TPG_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_output_latch_r     <= TPG_RST_LATCH;
            port_direction_r        <= TPG_RST_DIR;
            port_pullup_enable_r    <= TPG_RST_PULLUP;
            standby_pin_state_sel_r <= TPG_RST_STANDBY[TPG_SPL_BIT];
        end else begin
            if (wr_latch) port_output_latch_r <= wbyte;
            if (wr_dir) port_direction_r <= wbyte;
            if (wr_pu) port_pullup_enable_r <= wbyte;
            if (wr_stby) standby_pin_state_sel_r <= w_data_r[TPG_SPL_BIT];
        end
    end

    // ****************************************
    // Pin cells
    // ****************************************
    wire       float_en = standby_pin_state_sel_r & (stop_mode | watch_mode);
    logic [1:0] oe_c;
    logic [1:0] out_c;
    logic [1:0] pu_c;
    logic [1:0] in_c;
    tpg_pad_s   pad_r;
    logic [1:0] in_r;

    for (genvar i = 0; i < 2; i++) begin : g_pin
        tpg_pad u_pad (
            .dir      (port_direction_r[TPG_PIN_LO + i]),
            .latch    (port_output_latch_r[TPG_PIN_LO + i]),
            .pu_sel   (port_pullup_enable_r[TPG_PIN_LO + i]),
            .pin_in   (pin_in[i]),
            .float_en (float_en),
            .oe       (oe_c[i]),
            .out      (out_c[i]),
            .pu       (pu_c[i]),
            .in_gated (in_c[i])
        );
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_r                <= '0;
            in_r                 <= 2'h0;
            position_trigger_one <= 1'b0;
            position_trigger_two <= 1'b0;
        end else begin
            pad_r                <= '{oe: oe_c, out: out_c, pu: pu_c};
            in_r                 <= in_c;
            position_trigger_one <= in_c[0];
            position_trigger_two <= in_c[1];
        end
    end
    assign pad = pad_r;

    // ****************************************
    // Read path
    // ****************************************
    wire       ar_take = s_axi_arvalid & s_axi_arready;
    wire [3:0] ar_off  = {s_axi_araddr[3:2], 2'b00};
    wire       ar_rmw  = s_axi_araddr[4];
    wire [7:0] pin_rd  = {5'h0, in_r, 1'b0};
    wire [7:0] dir_m   = port_direction_r & TPG_PIN_MASK;
    wire [7:0] data_rd = ar_rmw ? port_output_latch_r
                       : (dir_m & port_output_latch_r) | (~dir_m & pin_rd);
    wire [7:0] rd_byte = (ar_off == TPG_OFS_LATCH)   ? data_rd
                       : (ar_off == TPG_OFS_DIR)     ? port_direction_r
                       : (ar_off == TPG_OFS_PULLUP)  ? port_pullup_enable_r
                       : (ar_off == TPG_OFS_STANDBY) ? {5'h0, watch_mode, stop_mode,
                                                        standby_pin_state_sel_r}
                       : 8'h00;
    wire       rd_hit  = ~ar_rmw | (ar_off == TPG_OFS_RMW);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= TPG_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_hit ? {24'h0, rd_byte} : 32'h0;
                s_axi_rresp  <= rd_hit ? TPG_RESP_OKAY : TPG_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_drive;
        @(posedge clk) disable iff (rst)
        (port_direction_r[TPG_PIN_LO] & ~float_en) |=> pad.oe[0] && pad.out[0] == $past(port_output_latch_r[TPG_PIN_LO]);
    endproperty
    a_drive: assert property (p_drive) else $error("output pin not driven");

    property p_input;
        @(posedge clk) disable iff (rst)
        ~port_direction_r[TPG_PIN_HI] |=> ~pad.oe[1];
    endproperty
    a_input: assert property (p_input) else $error("input pin driven");

    property p_float;
        @(posedge clk) disable iff (rst)
        float_en |=> pad.oe == 2'h0 && pad.pu == 2'h0 && in_r == 2'h0;
    endproperty
    a_float: assert property (p_float) else $error("standby float broken");

    property p_keep;
        @(posedge clk) disable iff (rst)
        (~standby_pin_state_sel_r & (stop_mode | watch_mode))
        |=> pad.oe == $past(port_direction_r[TPG_PIN_HI:TPG_PIN_LO])
            && pad.out == $past(port_output_latch_r[TPG_PIN_HI:TPG_PIN_LO]);
    endproperty
    a_keep: assert property (p_keep) else $error("standby changed pins");

    property p_pulow;
        @(posedge clk) disable iff (rst)
        (pad.oe[0] & ~pad.out[0]) |-> ~pad.pu[0];
    endproperty
    a_pulow: assert property (p_pulow) else $error("pull-up on low output");

    property p_rdout;
        @(posedge clk) disable iff (rst)
        (ar_take & ~ar_rmw & ar_off == TPG_OFS_LATCH & port_direction_r[TPG_PIN_LO])
        |=> s_axi_rvalid && s_axi_rdata[TPG_PIN_LO] == $past(port_output_latch_r[TPG_PIN_LO]);
    endproperty
    a_rdout: assert property (p_rdout) else $error("output read not latch");

    property p_rmw;
        @(posedge clk) disable iff (rst)
        (ar_take & ar_rmw & ar_off == TPG_OFS_RMW)
        |=> s_axi_rdata[7:0] == $past(port_output_latch_r);
    endproperty
    a_rmw: assert property (p_rmw) else $error("rmw read not latch");

    property p_unused;
        @(posedge clk) disable iff (rst)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (port_direction_r & ~TPG_PIN_MASK) == 8'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits nonzero");

    property p_trig;
        @(posedge clk) disable iff (rst)
        1'b1 |=> position_trigger_two == $past(in_c[1]);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger not following pin");

    c_write: cover property (@(posedge clk) disable iff (rst) wr_latch);
    c_float: cover property (@(posedge clk) disable iff (rst) float_en);
    c_rmw:   cover property (@(posedge clk) disable iff (rst) ar_take & ar_rmw);
endmodule
